// ==== sim/tb.sv ====
// Self-checking bench for the two-channel modulo timer with compare and PWM outputs.
// Assumes the design checks its own assertions; the bench drives every port itself.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pwm_timer_pkg::*;
  // ----------------------------------------
  // Stimulus table and signals
  // ----------------------------------------
  // One steady-state PWM case: expected high ticks of the pin per period.
  typedef struct {
    logic [15:0] wrap;
    logic [15:0] cmp;
    logic [2:0] presc;
    logic [1:0] act;
    logic tov;
    logic full;
    int hi_ticks;
  } row_t;
  // The pin rises one clock after the wrap and falls one clock after the match, so a pulse lasts cmp ticks.
  // A compare value of zero meets the wrap in one cycle; the forced level wins, giving 0% duty.
  row_t rows [8] = '{
    '{16'h0007, 16'h0002, 3'h0, ACT_CLEAR, 1'b1, 1'b0, 2},
    '{16'h0007, 16'h0002, 3'h0, ACT_SET, 1'b1, 1'b0, 6},
    '{16'h0007, 16'h0002, 3'h0, ACT_CLEAR, 1'b0, 1'b0, 0},
    '{16'h0007, 16'h0002, 3'h0, ACT_CLEAR, 1'b1, 1'b1, 8},
    '{16'h00FF, 16'h0080, 3'h0, ACT_CLEAR, 1'b1, 1'b0, 128},
    '{16'h0003, 16'h0000, 3'h2, ACT_CLEAR, 1'b1, 1'b0, 0},
    '{16'h0007, 16'h0006, 3'h1, ACT_SET, 1'b1, 1'b0, 2},
    '{16'h0007, 16'h0002, 3'h0, ACT_TOGGLE, 1'b0, 1'b0, 4}
  };
  logic mclk, reset_n, counter_halt, counter_clear, wrap_irq_enable, wrap_flag_clear;
  logic [2:0] presc_sel;
  logic [15:0] wrap_value, chan0_compare, chan1_compare, count_r;
  chan_cfg_t chan0_cfg, chan1_cfg, c;
  logic chan0_compare_wr, chan1_compare_wr, chan0_flag_clear, chan1_flag_clear;
  logic wrap_flag, wrap_irq, chan0_event_flag, chan1_event_flag, chan0_irq, chan1_irq;
  logic chan0_pin, chan0_pin_oe_n, chan1_pin, chan1_pin_oe_n, chan1_gpio_free, active_owner;
  logic [15:0] mx;
  logic p;
  int err_total, n_tests, per, h0, h1;

  pwm_timer DUT (
    .mclk, .reset_n, .counter_halt, .counter_clear, .presc_sel, .wrap_value,
    .wrap_irq_enable, .wrap_flag_clear, .chan0_cfg, .chan1_cfg, .chan0_compare,
    .chan0_compare_wr, .chan1_compare, .chan1_compare_wr, .chan0_flag_clear,
    .chan1_flag_clear, .count_r, .wrap_flag, .wrap_irq, .chan0_event_flag,
    .chan1_event_flag, .chan0_irq, .chan1_irq, .chan0_pin, .chan0_pin_oe_n,
    .chan1_pin, .chan1_pin_oe_n, .chan1_gpio_free, .active_owner
  );

  // Free-running 100 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  // Compares one value; four-state equality so an unknown never passes.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then stops the run.
  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Lets n edges pass and samples after their updates have landed.
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // Counts high cycles of both pins and the largest count seen.
  task automatic measure(input int n);
    h0 = 0;
    h1 = 0;
    mx = 16'h0000;
    repeat (n) begin
      cyc(1);
      if (chan0_pin === 1'b1) h0++;
      if (chan1_pin === 1'b1) h1++;
      if (count_r > mx) mx = count_r;
    end
  endtask

  // Bounded wait for a counter value; running out ends the run as a failure.
  task automatic wait_cnt(input logic [15:0] v);
    int k;
    k = 0;
    while (count_r !== v && k < 2000) begin
      cyc(1);
      k++;
    end
    if (k >= 2000) begin
      err_total++;
      end_sim();
    end
  endtask

  // Single-cycle compare write on one channel.
  task automatic wr_cmp(input logic ch, input logic [15:0] v);
    @(posedge mclk);
    chan0_compare <= v;
    chan1_compare <= v;
    chan0_compare_wr <= ~ch;
    chan1_compare_wr <= ch;
    @(posedge mclk);
    chan0_compare_wr <= 1'b0;
    chan1_compare_wr <= 1'b0;
  endtask

  // Short reset, then the halted, cleared initialisation sequence.
  task automatic setup(input logic [15:0] wv, input logic [2:0] ps, input chan_cfg_t c0,
                       input chan_cfg_t c1, input logic [15:0] v0, input logic w1);
    @(posedge mclk);
    reset_n <= 1'b0;
    @(posedge mclk);
    reset_n <= 1'b1;
    counter_halt <= 1'b1;
    counter_clear <= 1'b1;
    wrap_value <= wv;
    presc_sel <= ps;
    wr_cmp(1'b0, v0);
    if (w1) wr_cmp(1'b1, v0);
    chan0_cfg <= c0;
    chan1_cfg <= c1;
    counter_clear <= 1'b0;
    @(posedge mclk);
    counter_halt <= 1'b0;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    err_total = 0;
    n_tests = 0;
    {reset_n, counter_halt, counter_clear, wrap_irq_enable, wrap_flag_clear} = 5'h00;
    {chan0_compare_wr, chan1_compare_wr, chan0_flag_clear, chan1_flag_clear} = 4'h0;
    presc_sel = 3'h0;
    wrap_value = 16'h0007;
    chan0_compare = 16'h0000;
    chan1_compare = 16'h0000;
    chan0_cfg = '0;
    chan1_cfg = '0;
    cyc(12);
    // Outputs idle and pins undriven while held in reset.
    chk({count_r, wrap_flag, chan0_event_flag, chan0_pin, chan1_gpio_free}, 32'h0);
    chk({chan0_pin_oe_n, chan1_pin_oe_n}, 32'h3);
    // Table of steady-state PWM cases on both channels at once.
    foreach (rows[i]) begin
      c = '{MODE_UNBUF, rows[i].act, rows[i].tov, rows[i].full, i[0]};
      setup(rows[i].wrap, rows[i].presc, c, c, rows[i].cmp, 1'b1);
      wrap_irq_enable <= ~i[0];
      per = (int'(rows[i].wrap) + 1) << rows[i].presc;
      cyc(3 * per);
      measure(2 * per);
      chk(h0, (2 * rows[i].hi_ticks) << rows[i].presc);
      chk(h1, (2 * rows[i].hi_ticks) << rows[i].presc);
      chk(mx, rows[i].wrap);
      chk({wrap_flag, wrap_irq}, {1'b1, ~i[0]});
      chk({chan0_event_flag, chan0_irq, chan1_event_flag, chan1_irq}, {2{1'b1, i[0]}});
      chk({chan0_pin_oe_n, chan1_pin_oe_n, chan1_gpio_free}, 32'h0);
    end
    // A compare value moved below the count already passed gives no match.
    c = '{MODE_UNBUF, ACT_CLEAR, 1'b1, 1'b0, 1'b1};
    setup(16'h00FF, 3'h0, c, c, 16'h00C0, 1'b1);
    wrap_irq_enable <= 1'b1;
    cyc(300);
    wait_cnt(16'h0080);
    @(posedge mclk);
    chan0_flag_clear <= 1'b1;
    wr_cmp(1'b0, 16'h0040);
    chan0_flag_clear <= 1'b0;
    wait_cnt(16'h00F0);
    chk({chan0_pin, chan0_event_flag, chan0_irq}, 32'h4);
    chk({chan1_pin, chan1_event_flag}, 32'h1);
    // Second disturbed period: the wrap turns the still-high pin low and the new match keeps it low.
    wait_cnt(16'h0050);
    chk({chan0_pin, chan0_event_flag}, 32'h1);
    // A shorter width written after this period's compare takes effect cleanly next period.
    wr_cmp(1'b0, 16'h0020);
    measure(256);
    chk(h0, 32'h20);
    chk(h1, 32'hC0);
    // Halt freezes the counter and the pin; clear zeroes the counter even while halted.
    @(posedge mclk);
    counter_halt <= 1'b1;
    wrap_flag_clear <= 1'b1;
    @(posedge mclk);
    wrap_flag_clear <= 1'b0;
    cyc(3);
    mx = count_r;
    p = chan0_pin;
    cyc(300);
    chk({count_r, chan0_pin}, {mx, p});
    chk({wrap_flag, wrap_irq}, 32'h0);
    @(posedge mclk);
    counter_clear <= 1'b1;
    @(posedge mclk);
    counter_clear <= 1'b0;
    cyc(3);
    chk(count_r, 16'h0000);
    // Linked pair: both mode bits set, channel 1 control carries junk.
    setup(16'h0007, 3'h0, '{2'h3, ACT_CLEAR, 1'b1, 1'b0, 1'b0},
          '{MODE_UNBUF, ACT_SET, 1'b1, 1'b0, 1'b1}, 16'h0002, 1'b0);
    cyc(24);
    chk(active_owner, OWN_CH0);
    measure(16);
    chk(h0, 4);
    chk({chan1_gpio_free, chan1_pin_oe_n, chan1_event_flag, chan1_irq}, 32'hC);
    wr_cmp(1'b1, 16'h0005);
    cyc(16);
    chk(active_owner, OWN_CH1);
    measure(16);
    chk(h0, 10);
    wr_cmp(1'b0, 16'h0001);
    cyc(16);
    chk(active_owner, OWN_CH0);
    measure(16);
    chk(h0, 2);
    end_sim();
  end
endmodule // tb
`default_nettype wire

// ==== verilog/pwm_timer.sv ====
// Two-channel output compare / PWM timer with buffered linked mode.
// Assumes software drives control ports synchronously; flag clears are pulses.
`timescale 1ns/1ps
`default_nettype none
module pwm_timer
  import pwm_timer_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic counter_halt,
  input wire logic counter_clear,
  input wire logic [2:0] presc_sel,
  input wire logic [15:0] wrap_value,
  input wire logic wrap_irq_enable,
  input wire logic wrap_flag_clear,
  input wire chan_cfg_t chan0_cfg,
  input wire chan_cfg_t chan1_cfg,
  input wire logic [15:0] chan0_compare,
  input wire logic chan0_compare_wr,
  input wire logic [15:0] chan1_compare,
  input wire logic chan1_compare_wr,
  input wire logic chan0_flag_clear,
  input wire logic chan1_flag_clear,
  output logic [15:0] count_r,
  output logic wrap_flag,
  output logic wrap_irq,
  output logic chan0_event_flag,
  output logic chan1_event_flag,
  output logic chan0_irq,
  output logic chan1_irq,
  output logic chan0_pin,
  output logic chan0_pin_oe_n,
  output logic chan1_pin,
  output logic chan1_pin_oe_n,
  output logic chan1_gpio_free,
  output logic active_owner
);
  // ----------------------------------------
  // Counter
  // ----------------------------------------
  logic tick_r; // Counter advanced this cycle.
  logic wrap_r; // Counter sat at the modulo value on that tick.

  // Halt and clear reach the counter directly.
  wrap_counter u_cnt (
    .mclk(mclk),
    .reset_n(reset_n),
    .counter_halt(counter_halt),
    .counter_clear(counter_clear),
    .presc_sel(presc_sel),
    .wrap_value(wrap_value),
    .count_r(count_r),
    .tick_r(tick_r),
    .wrap_r(wrap_r)
  );

  // ----------------------------------------
  // Compare registers and linking
  // ----------------------------------------
  logic [15:0] cmp_r [2]; // Channel compare values; unknown until written in the real part.
  logic linked; // Buffered pair in effect.
  owner_t owner_r; // Pair that drives the linked output.
  owner_t last_wr_r; // Pair written most recently.
  logic [1:0] mode_eff [2]; // Mode after link override.
  logic [1:0] act_eff [2];
  logic [1:0] tov_eff;
  logic [1:0] max_eff;
  logic [1:0] ie_eff;
  logic [1:0] match;

  // The buffer bit alone decides linking, whatever the other mode bit holds.
  assign linked = chan0_cfg.mode_sel[1];

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      cmp_r[0] <= CNT_ZERO;
      cmp_r[1] <= CNT_ZERO;
    end else begin
      if (chan0_compare_wr) cmp_r[0] <= chan0_compare;
      if (chan1_compare_wr) cmp_r[1] <= chan1_compare;
    end
  end

  // While linked, ownership only changes at a wrap, so a write to the idle pair waits a period; unlinking resets it to OWN_CH0.
  always_ff @(posedge mclk) begin
    if (!reset_n || !linked) begin
      last_wr_r <= OWN_CH0;
      owner_r <= OWN_CH0;
    end else begin
      if (chan1_compare_wr) last_wr_r <= OWN_CH1;
      else if (chan0_compare_wr) last_wr_r <= OWN_CH0;
      if (wrap_r) owner_r <= last_wr_r;
    end
  end

  // Channel 1 control is ignored while linked.
  always_comb begin
    mode_eff[0] = linked ? MODE_BUF : chan0_cfg.mode_sel;
    mode_eff[1] = linked ? 2'h0 : chan1_cfg.mode_sel;
    act_eff[0] = chan0_cfg.action_sel;
    act_eff[1] = chan1_cfg.action_sel;
    tov_eff = {chan1_cfg.toggle_on_wrap && !linked, chan0_cfg.toggle_on_wrap};
    max_eff = {chan1_cfg.full_duty && !linked, chan0_cfg.full_duty};
    ie_eff = {chan1_cfg.irq_enable && !linked, chan0_cfg.irq_enable};
  end

  // A match needs equality on a tick, so a value already passed is silent this period.
  assign match[0] = tick_r && (mode_eff[0] != 2'h0) &&
                    (count_r == (linked && owner_r == OWN_CH1 ? cmp_r[1] : cmp_r[0]));
  assign match[1] = tick_r && (mode_eff[1] != 2'h0) && (count_r == cmp_r[1]);

  // ----------------------------------------
  // Pin drivers, one per channel
  // ----------------------------------------
  logic [1:0] pin_r;
  logic [1:0] flag_r;
  logic [1:0] flag_clr;
  assign flag_clr = {chan1_flag_clear, chan0_flag_clear};

  for (genvar c = 0; c < 2; c++) begin : g_chan
    // Wrap toggles first; a same-cycle match force still wins.
    always_ff @(posedge mclk) begin
      if (!reset_n) begin
        pin_r[c] <= 1'b0;
      end else if (mode_eff[c] != 2'h0) begin
        if (max_eff[c] && tov_eff[c]) begin
          pin_r[c] <= 1'b1;
        end else if (match[c] && act_eff[c] == ACT_CLEAR) begin
          pin_r[c] <= 1'b0;
        end else if (match[c] && act_eff[c] == ACT_SET) begin
          pin_r[c] <= 1'b1;
        end else if (match[c] && act_eff[c] == ACT_TOGGLE) begin
          pin_r[c] <= !pin_r[c];
        end else if (wrap_r && tov_eff[c]) begin
          pin_r[c] <= !pin_r[c];
        end
      end
    end

    // Set wins over a clear in the same cycle.
    always_ff @(posedge mclk) begin
      if (!reset_n) begin
        flag_r[c] <= 1'b0;
      end else if (match[c]) begin
        flag_r[c] <= 1'b1;
      end else if (flag_clr[c]) begin
        flag_r[c] <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Flags, requests and registered outputs
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      wrap_flag <= 1'b0;
    end else if (wrap_r) begin
      wrap_flag <= 1'b1;
    end else if (wrap_flag_clear) begin
      wrap_flag <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      wrap_irq <= 1'b0;
      chan0_irq <= 1'b0;
      chan1_irq <= 1'b0;
      chan0_event_flag <= 1'b0;
      chan1_event_flag <= 1'b0;
    end else begin
      wrap_irq <= (wrap_flag || wrap_r) && wrap_irq_enable;
      chan0_irq <= (flag_r[0] || match[0]) && ie_eff[0];
      chan1_irq <= (flag_r[1] || match[1]) && ie_eff[1];
      chan0_event_flag <= flag_r[0] || match[0];
      chan1_event_flag <= (flag_r[1] || match[1]) && !linked;
    end
  end

  // Channel 1 pin is released (enable high) while linked.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      chan0_pin <= 1'b0;
      chan1_pin <= 1'b0;
      chan0_pin_oe_n <= 1'b1;
      chan1_pin_oe_n <= 1'b1;
      chan1_gpio_free <= 1'b0;
      active_owner <= 1'b0;
    end else begin
      chan0_pin <= pin_r[0];
      chan1_pin <= pin_r[1];
      chan0_pin_oe_n <= (mode_eff[0] == 2'h0);
      chan1_pin_oe_n <= (mode_eff[1] == 2'h0);
      chan1_gpio_free <= linked;
      active_owner <= owner_r;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_link_owner_wrap: assert property (@(posedge mclk) disable iff (!reset_n)
    linked && $past(linked) && $past(reset_n) && owner_r != $past(owner_r) |-> $past(wrap_r))
    else $error("owner changed without a wrap");
  chk_owner_follows: assert property (@(posedge mclk) disable iff (!reset_n)
    linked && wrap_r && !chan0_compare_wr && !chan1_compare_wr |=> $stable(linked) |-> owner_r == $past(last_wr_r))
    else $error("owner did not follow last written pair");
  chk_wrap_flag_set: assert property (@(posedge mclk) disable iff (!reset_n)
    wrap_r |=> wrap_flag)
    else $error("wrap flag not set");
  chk_wrap_irq_gate: assert property (@(posedge mclk) disable iff (!reset_n)
    wrap_irq |-> $past(wrap_irq_enable))
    else $error("wrap request while disabled");
  chk_chan_flag_set: assert property (@(posedge mclk) disable iff (!reset_n)
    match[0] |=> flag_r[0] ##1 chan0_event_flag)
    else $error("channel flag not set on match");
  chk_clear_action: assert property (@(posedge mclk) disable iff (!reset_n)
    match[0] && act_eff[0] == ACT_CLEAR && !(max_eff[0] && tov_eff[0]) |=> !pin_r[0] ##1 !chan0_pin)
    else $error("clear on compare failed");
  chk_full_duty: assert property (@(posedge mclk) disable iff (!reset_n)
    mode_eff[0] != 2'h0 && max_eff[0] && tov_eff[0] |=> pin_r[0])
    else $error("full duty not high");
  chk_no_toggle_hold: assert property (@(posedge mclk) disable iff (!reset_n)
    wrap_r && !tov_eff[0] && !match[0] |=> $stable(pin_r[0]))
    else $error("pin toggled without toggle-on-wrap");
  chk_link_releases: assert property (@(posedge mclk) disable iff (!reset_n)
    linked |=> chan1_pin_oe_n && chan1_gpio_free)
    else $error("channel 1 pin not released");
  chk_halt_freeze: assert property (@(posedge mclk) disable iff (!reset_n)
    counter_halt && !counter_clear |=> $stable(count_r) && !wrap_r)
    else $error("counter moved while halted");

  cov_linked_swap: cover property (@(posedge mclk) linked && wrap_r && last_wr_r != owner_r);
  cov_pwm_clear: cover property (@(posedge mclk) match[0] && act_eff[0] == ACT_CLEAR);
  cov_wrap_toggle: cover property (@(posedge mclk) wrap_r && tov_eff[0]);
endmodule // pwm_timer
`default_nettype wire

// ==== verilog/pwm_timer_pkg.sv ====
// Package for the two-channel modulo timer with output compare and PWM.
// Assumes a single mclk domain; software control arrives as plain ports.
package pwm_timer_pkg;
  // ----------------------------------------
  // Widths and reset values
  // ----------------------------------------
  localparam int CNT_W = 16;
  localparam logic [15:0] WRAP_RESET = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [2:0] PRESC_ZERO = 3'h0;
  localparam logic [6:0] DIV_ZERO = 7'h00;
  localparam logic [6:0] DIV_ONE = 7'h01;
  localparam logic [2:0] PS_UNUSED = 3'h7;
  // ----------------------------------------
  // Field encodings
  // ----------------------------------------
  localparam logic [1:0] MODE_UNBUF = 2'h1;
  localparam logic [1:0] MODE_BUF = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;

  // Per-channel control bits as software programs them.
  typedef struct packed {
    logic [1:0] mode_sel;     // High bit is chan_mode_sel_hi.
    logic [1:0] action_sel;   // High bit is chan_action_sel_hi.
    logic toggle_on_wrap;
    logic full_duty;
    logic irq_enable;
  } chan_cfg_t;

  // Owner of the output in linked mode.
  typedef enum logic [0:0] {
    OWN_CH0 = 1'b0,
    OWN_CH1 = 1'b1
  } owner_t;
endpackage

// ==== verilog/wrap_counter.sv ====
// Prescaled 16-bit modulo counter.
// Assumes halt and clear are synchronous to mclk.
`timescale 1ns/1ps
`default_nettype none
module wrap_counter
  import pwm_timer_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic counter_halt,
  input wire logic counter_clear,
  input wire logic [2:0] presc_sel,
  input wire logic [15:0] wrap_value,
  output logic [15:0] count_r,
  output logic tick_r,
  output logic wrap_r
);
  // ----------------------------------------
  // Prescaler
  // ----------------------------------------
  logic [6:0] div_r; // Free prescaler count.
  logic [6:0] div_mask; // Low bits that must be all ones for a tick.
  logic tick_nxt;
  assign div_mask = (presc_sel == PS_UNUSED) ? DIV_ZERO : 7'((DIV_ONE << presc_sel) - DIV_ONE);
  assign tick_nxt = !counter_halt && !counter_clear && (presc_sel != PS_UNUSED) && ((div_r & div_mask) == div_mask);

  // Prescaler is cleared with the counter by the clear bit.
  always_ff @(posedge mclk) begin
    if (!reset_n || counter_clear) begin
      div_r <= DIV_ZERO;
    end else if (!counter_halt) begin
      div_r <= div_r + DIV_ONE;
    end
  end

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  // Counts 0..wrap inclusive, so a wrap of 00FF gives 256 ticks.
  always_ff @(posedge mclk) begin
    if (!reset_n || counter_clear) begin
      count_r <= CNT_ZERO;
    end else if (tick_nxt) begin
      count_r <= (count_r == wrap_value) ? CNT_ZERO : count_r + 16'h0001;
    end
  end

  // Wrap pulse marks the tick on which the counter sits at the modulo value.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      tick_r <= 1'b0;
      wrap_r <= 1'b0;
    end else begin
      tick_r <= tick_nxt;
      wrap_r <= tick_nxt && (count_r == wrap_value);
    end
  end

  chk_wrap_restart: assert property (@(posedge mclk) disable iff (!reset_n)
    wrap_r && !counter_clear |-> count_r == CNT_ZERO)
    else $error("counter did not restart at zero after wrap");
endmodule // wrap_counter
`default_nettype wire
